// ### fpp_pkg.sv
// ============================================================
// Shared constants for the fuse PROM programmer.
package fpp_pkg;

  // ==========================================================
  // Array shape.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  localparam int BIT_W = 2;

  // ==========================================================
  // Clock and printed times, in nanoseconds.
  localparam int CLK_NS = 50;
  localparam int PW_NS = 7500;
  localparam int PS_NS = 700;
  localparam int SA_NS = 500;
  localparam int HA_NS = 500;

  // Cycle counts; least times round up.
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] PW_CYC = TMR_W'((PW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] PS_CYC = TMR_W'((PS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] SA_CYC = TMR_W'((SA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] HA_CYC = TMR_W'((HA_NS + CLK_NS - 1) / CLK_NS);
  // Cycles an input takes through the three-stage synchroniser.
  localparam logic [TMR_W-1:0] SYNC_LAT = 8'h04;

  // ==========================================================
  // Pulse counts.
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] MAX_PULSES = 7'h64;
  localparam logic [2:0] EXTRA_PULSES = 3'h4;

  // ==========================================================
  // Sequencer states.
  typedef enum logic [3:0] {
    FPP_IDLE,
    FPP_SETUP,
    FPP_SENSE,
    FPP_PULSE,
    FPP_RECHK,
    FPP_RESENSE,
    FPP_GAP,
    FPP_READ,
    FPP_HOLD
  } fpp_state_t;

endpackage

// ### fpp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Three-stage input synchroniser with agreement filter.
module fpp_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i, // Core clock.
  input wire logic rst_b_i, // Synchronous reset, active low.
  input wire logic [W-1:0] async_i, // Input from outside the domain.
  output logic [W-1:0] sync_o // Filtered, synchronised level.
);

  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  // The first stage feeds only the second; a change is accepted once
  // the second and third stages agree, so a runt of one cycle is never taken.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
      sync_o <= '0;
    end
    else
    begin
      ff1 <= async_i;
      ff2 <= ff1;
      ff3 <= ff2;
      if (ff2 == ff3)
        sync_o <= ff3;
    end
  end

endmodule
`default_nettype wire

// ### fpp_programmer.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host-side programmer and reader for a 256x4 fuse PROM.
// Functional notes
// R1: Blank cells read zero; programming only turns one chosen cell to one.
// R2: Device outputs float whenever either active-low select is high.
// R3: Device drives the addressed word only while both selects are low.
// R4: Device outputs have driven-zero, driven-one and off states.
// R5: Address the word with eight lines, keep a select high while programming.
// R6: Repeat pulses and stop as soon as sensing shows the bit is one.
// R7: After the bit first reads one, apply exactly four more pulses.
// R8: Drive programming current into only one output at a time.
// R9: Verify by driving both selects low and reading the word.
// R10: Keep programming pulse duty cycle at 70 percent or more.
// R11: Wait at least 700 ns after each pulse before the sense strobe.
// R12: Never enable two devices sharing an output bus together.
// R13: Array is 256 words of 4 bits, fully decoded.
// R14: Re-sense after a gap of a pulse width; resume pulsing if zero.
// R15: Sense current is off whenever the address changes.
// R16: Mark the bit failed after the maximum pulse count without success.
module fpp_programmer
  import fpp_pkg::*;
(
  input wire logic core_clk_i, // Core clock, 20 MHz.
  input wire logic rst_b_i, // Synchronous reset, active low.
  input wire logic start_prog_i, // Pulse: program one bit.
  input wire logic start_read_i, // Pulse: read one word.
  input wire logic [ADDR_W-1:0] addr_i, // Target word.
  input wire logic [BIT_W-1:0] bit_i, // Target output for programming.
  input wire logic sense_one_i, // Comparator: sensed bit is one.
  input wire logic [DATA_W-1:0] data_i, // Device data outputs.
  output logic [ADDR_W-1:0] addr_o, // Device address pins.
  output logic ce1_b_o, // Device select 1, active low.
  output logic ce2_b_o, // Device select 2, active low.
  output logic [DATA_W-1:0] prog_en_o, // Programming current per output.
  output logic [DATA_W-1:0] sense_en_o, // Sense current per output.
  output logic busy_o, // Operation in progress.
  output logic done_o, // Pulse: operation finished.
  output logic fail_o, // Last programming failed.
  output logic [DATA_W-1:0] rdata_o // Last word read.
);

  // ==========================================================
  // Synchronised device inputs.
  logic [DATA_W:0] pins_s;

  fpp_sync #(.W(DATA_W + 1)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({sense_one_i, data_i}),
    .sync_o(pins_s)
  );

  wire logic bit_one = pins_s[DATA_W];
  wire logic [DATA_W-1:0] data_s = pins_s[DATA_W-1:0];

  // ==========================================================
  // State.
  fpp_state_t state;
  fpp_state_t next_state;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic [CNT_W-1:0] pulses;
  logic [CNT_W-1:0] next_pulses;
  logic [2:0] extra;
  logic [2:0] next_extra;
  logic [BIT_W-1:0] sel_bit;
  logic next_fail;
  logic next_done;
  logic next_prog;
  logic next_sense;

  // One-hot output select guarantees a single output takes current.
  wire logic [DATA_W-1:0] bit_mask = DATA_W'(1) << sel_bit; // R8
  wire logic tmr_done = (tmr == '0);
  wire logic at_max = (pulses == MAX_PULSES);
  wire logic idle = (state == FPP_IDLE);
  wire logic strobe = (state == FPP_SENSE) && tmr_done;
  wire logic restrobe = (state == FPP_RESENSE) && tmr_done;
  wire logic [TMR_W-1:0] sense_wait = PS_CYC + SYNC_LAT; // R11

  // ==========================================================
  // Sequencer: sense, pulse, re-check, extra pulses, hold.
  always_comb
  begin
    next_state = state;
    next_tmr = tmr_done ? tmr : tmr - 1'b1;
    next_pulses = pulses;
    next_extra = extra;
    next_fail = fail_o;
    next_done = 1'b0;
    next_prog = 1'b0;
    next_sense = 1'b0;
    case (state)
      FPP_IDLE:
      begin
        if (start_prog_i)
        begin
          next_state = FPP_SETUP;
          next_tmr = SA_CYC;
          next_pulses = '0;
          next_extra = '0;
          next_fail = 1'b0;
        end
        else if (start_read_i)
        begin
          next_state = FPP_READ;
          next_tmr = SA_CYC + SYNC_LAT;
        end
      end
      FPP_SETUP:
      begin
        if (tmr_done)
        begin
          // Sense only after the address has settled.
          next_state = FPP_SENSE; // R15
          next_tmr = sense_wait;
          next_sense = 1'b1;
        end
      end
      FPP_SENSE:
      begin
        next_sense = !tmr_done;
        if (tmr_done)
        begin
          if (bit_one && extra == EXTRA_PULSES)
            next_state = FPP_HOLD; // R7
          else if (bit_one && pulses == '0)
            next_state = FPP_HOLD; // R1
          else if (bit_one)
          begin
            // Train stops; confirm after a pulse-width pause.
            next_state = FPP_RECHK; // R6
            next_tmr = PW_CYC; // R14
          end
          else if (at_max)
          begin
            next_state = FPP_HOLD; // R16
            next_fail = 1'b1;
          end
          else
          begin
            // Short sense gap keeps duty near 90 percent.
            next_state = FPP_PULSE; // R10
            next_tmr = PW_CYC;
            next_pulses = pulses + 1'b1;
            next_extra = '0;
            next_prog = 1'b1;
          end
        end
      end
      FPP_PULSE:
      begin
        next_prog = !tmr_done;
        if (tmr_done && extra != '0 && extra != EXTRA_PULSES)
        begin
          next_state = FPP_GAP;
          next_tmr = sense_wait;
        end
        else if (tmr_done)
        begin
          next_state = FPP_SENSE; // R11
          next_tmr = sense_wait;
          next_sense = 1'b1;
        end
      end
      FPP_RECHK:
      begin
        if (tmr_done)
        begin
          next_state = FPP_RESENSE; // R14
          next_tmr = sense_wait;
          next_sense = 1'b1;
        end
      end
      FPP_RESENSE:
      begin
        next_sense = !tmr_done;
        if (restrobe && bit_one)
        begin
          next_state = FPP_PULSE; // R7
          next_tmr = PW_CYC;
          next_extra = 3'h1;
          next_prog = 1'b1;
        end
        else if (restrobe && at_max)
        begin
          next_state = FPP_HOLD; // R16
          next_fail = 1'b1;
        end
        else if (restrobe)
        begin
          next_state = FPP_PULSE; // R14
          next_tmr = PW_CYC;
          next_pulses = pulses + 1'b1;
          next_prog = 1'b1;
        end
      end
      FPP_GAP:
      begin
        if (tmr_done)
        begin
          next_state = FPP_PULSE; // R7
          next_tmr = PW_CYC;
          next_extra = extra + 1'b1;
          next_prog = 1'b1;
        end
      end
      FPP_READ:
      begin
        if (tmr_done)
          next_state = FPP_HOLD; // R9
      end
      FPP_HOLD:
      begin
        if (tmr_done)
        begin
          next_state = FPP_IDLE;
          next_done = 1'b1;
        end
      end
      default:
        next_state = FPP_IDLE;
    endcase
    // Hold time starts as the hold state is entered.
    if (next_state == FPP_HOLD && state != FPP_HOLD)
      next_tmr = HA_CYC;
  end

  // ==========================================================
  // Sequencer registers.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      state <= FPP_IDLE;
      tmr <= '0;
      pulses <= '0;
      extra <= '0;
      fail_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tmr <= next_tmr;
      pulses <= next_pulses;
      extra <= next_extra;
      fail_o <= next_fail;
      done_o <= next_done;
    end
  end

  // ==========================================================
  // Pin registers. The address only moves from idle, where sense and
  // programming current are both off.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      addr_o <= '0;
      sel_bit <= '0;
      ce1_b_o <= 1'b1;
      ce2_b_o <= 1'b1;
      prog_en_o <= '0;
      sense_en_o <= '0;
      busy_o <= 1'b0;
      rdata_o <= '0;
    end
    else
    begin
      if (idle && (start_prog_i || start_read_i))
      begin
        addr_o <= addr_i; // R5 R15
        sel_bit <= bit_i;
      end
      // Selects drop only for a read, never in programming.
      ce1_b_o <= !(next_state == FPP_READ); // R5 R9 R12
      ce2_b_o <= !(next_state == FPP_READ); // R9
      prog_en_o <= next_prog ? bit_mask : '0; // R8
      sense_en_o <= next_sense ? bit_mask : '0; // R15
      busy_o <= (next_state != FPP_IDLE);
      if (state == FPP_READ && tmr_done)
        rdata_o <= data_s; // R9
    end
  end

endmodule
`default_nettype wire

// ### fpp_prom_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Behavioural fuse PROM of 256 words by 4 bits.
module fpp_prom_model
  import fpp_pkg::*;
(
  input wire logic core_clk_i, // Bench clock, used to spot pulse edges.
  input wire logic [ADDR_W-1:0] addr_i, // Address pins.
  input wire logic ce1_b_i, // Select 1, active low.
  input wire logic ce2_b_i, // Select 2, active low.
  input wire logic [DATA_W-1:0] prog_en_i, // Programming current.
  input wire logic [DATA_W-1:0] sense_en_i, // Sense current.
  input wire logic [10:0] need_i, // Pulses a blank cell needs.
  input wire logic relapse_i, // A fresh fuse falls back once after its sense.
  output logic [DATA_W-1:0] data_o, // Data pins.
  output logic sense_one_o // Comparator: sensed bit is one.
);
  logic [DATA_W-1:0] fuse [256];
  int hits [1024];
  logic [DATA_W-1:0] last_prog = '0;
  logic [DATA_W-1:0] last_data = '0;
  logic [DATA_W-1:0] last_sense = '0;
  bit relapsed [1024];
  wire logic sel = !ce1_b_i && !ce2_b_i;

  // Every cell starts blank, reading zero.
  initial
  begin
    foreach (fuse[i]) fuse[i] = '0;
    foreach (hits[i]) hits[i] = 0;
  end

  // Only a pulse into a deselected chip counts towards a blown fuse.
  always @(posedge core_clk_i)
  begin
    last_prog <= prog_en_i;
    if (sel)
      last_data <= fuse[addr_i];
    for (int b = 0; b < DATA_W; b++)
      if (prog_en_i[b] && !last_prog[b] && !sel)
      begin
        hits[addr_i * DATA_W + b]++;
        if (hits[addr_i * DATA_W + b] >= need_i)
          fuse[addr_i][b] = 1'b1;
      end
    // A relapsing fuse reads zero at its re-check, forcing a resumed train.
    last_sense <= sense_en_i;
    for (int b = 0; b < DATA_W; b++)
      if (relapse_i && last_sense[b] && !sense_en_i[b] && fuse[addr_i][b] &&
          !relapsed[addr_i * DATA_W + b])
      begin
        fuse[addr_i][b] = 1'b0;
        relapsed[addr_i * DATA_W + b] = 1'b1;
      end
  end

  // Off pins show the inverse of the last word, so a stale read fails.
  assign data_o = sel ? fuse[addr_i] : ~last_data;
  assign sense_one_o = !sel && |(sense_en_i & fuse[addr_i]);
endmodule
`default_nettype wire

// ### fpp_programmer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checker for the fuse PROM programmer.
module fpp_programmer_asserts
  import fpp_pkg::*;
(
  input wire logic core_clk_i, // Core clock.
  input wire logic rst_b_i, // Synchronous reset, active low.
  input wire logic start_prog_i, // Program request.
  input wire logic start_read_i, // Read request.
  input wire logic [ADDR_W-1:0] addr_i, // Target word.
  input wire logic [ADDR_W-1:0] addr_o, // Device address.
  input wire logic ce1_b_o, // Select 1.
  input wire logic ce2_b_o, // Select 2.
  input wire logic [DATA_W-1:0] prog_en_o, // Programming current.
  input wire logic [DATA_W-1:0] sense_en_o, // Sense current.
  input wire logic busy_o // Busy flag.
);
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  wire logic prog_on = |prog_en_o;

  // Saturating run lengths of pulse high and pulse low.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i || !prog_on)
      hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff)
      hi_cnt <= hi_cnt + 8'h01;
    if (!rst_b_i)
      lo_cnt <= 8'hff;
    else if (prog_on)
      lo_cnt <= 8'h00;
    else if (lo_cnt != 8'hff)
      lo_cnt <= lo_cnt + 8'h01;
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // ==========================================================
  // Sequences and properties.
  sequence s_pulse_end;
    $fell(prog_on);
  endsequence
  sequence s_read_go;
    start_read_i && !start_prog_i && !busy_o;
  endsequence
  property p_prog_desel;
    prog_on |-> (ce1_b_o || ce2_b_o);
  endproperty
  property p_prog_addr;
    prog_on |-> $stable(addr_o);
  endproperty
  property p_one_prog;
    $onehot0(prog_en_o) && !(prog_on && |sense_en_o);
  endproperty
  property p_addr_sense;
    $changed(addr_o) |-> sense_en_o == '0 && $past(sense_en_o) == '0;
  endproperty
  property p_read_sel;
    (!ce1_b_o && !ce2_b_o) |-> !prog_on && sense_en_o == '0;
  endproperty
  property p_width;
    s_pulse_end |-> hi_cnt >= 8'h90 && hi_cnt <= 8'h9c;
  endproperty
  property p_gap;
    $rose(prog_on) |-> lo_cnt >= 8'h0e;
  endproperty
  property p_read_start;
    s_read_go |=> busy_o && !ce1_b_o && !ce2_b_o && addr_o == $past(addr_i);
  endproperty
  property p_prog_start;
    start_prog_i && !busy_o |=> busy_o && (ce1_b_o || ce2_b_o);
  endproperty

  a_prog_desel: assert property (p_prog_desel)
    else $error("programming current while chip selected");
  a_prog_addr: assert property (p_prog_addr)
    else $error("address moved during a pulse");
  a_one_prog: assert property (p_one_prog)
    else $error("more than one output driven");
  a_addr_sense: assert property (p_addr_sense)
    else $error("sense current on across address change");
  a_read_sel: assert property (p_read_sel)
    else $error("current applied while chip selected");
  a_width: assert property (p_width)
    else $error("pulse width out of range");
  a_gap: assert property (p_gap)
    else $error("pulse followed too soon");
  a_read_start: assert property (p_read_start)
    else $error("read did not select the word");
  a_prog_start: assert property (p_prog_start)
    else $error("program did not start deselected");
endmodule

bind fpp_programmer fpp_programmer_asserts u_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .start_prog_i(start_prog_i),
  .start_read_i(start_read_i), .addr_i(addr_i), .addr_o(addr_o),
  .ce1_b_o(ce1_b_o), .ce2_b_o(ce2_b_o), .prog_en_o(prog_en_o),
  .sense_en_o(sense_en_o), .busy_o(busy_o));
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench: programmer against a behavioural PROM.
module tb;
  import fpp_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic start_prog_i = 1'b0;
  logic start_read_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [BIT_W-1:0] bit_i = '0;
  logic [10:0] need = 11'h001;
  logic relapse = 1'b0;
  logic prog_d = 1'b0;
  logic [ADDR_W-1:0] a;
  wire logic sense_one;
  wire logic ce1_b;
  wire logic ce2_b;
  wire logic busy;
  wire logic done;
  wire logic fail;
  wire logic [ADDR_W-1:0] addr_o;
  wire logic [DATA_W-1:0] data;
  wire logic [DATA_W-1:0] prog_en;
  wire logic [DATA_W-1:0] sense_en;
  wire logic [DATA_W-1:0] rdata;
  int fails = 0;
  int total_checks = 0;
  int pulses = 0;
  int n;
  int exp_mem [256];

  fpp_programmer dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .start_prog_i(start_prog_i), .start_read_i(start_read_i),
    .addr_i(addr_i), .bit_i(bit_i), .sense_one_i(sense_one), .data_i(data),
    .addr_o(addr_o), .ce1_b_o(ce1_b), .ce2_b_o(ce2_b), .prog_en_o(prog_en),
    .sense_en_o(sense_en), .busy_o(busy), .done_o(done), .fail_o(fail),
    .rdata_o(rdata));
  fpp_prom_model u_prom (.core_clk_i(core_clk_i), .addr_i(addr_o),
    .ce1_b_i(ce1_b), .ce2_b_i(ce2_b), .prog_en_i(prog_en),
    .sense_en_i(sense_en), .need_i(need), .relapse_i(relapse), .data_o(data),
    .sense_one_o(sense_one));

  always #25 core_clk_i = ~core_clk_i;

  // Count leading edges of programming pulses.
  always @(posedge core_clk_i)
  begin
    prog_d <= |prog_en;
    if (|prog_en && !prog_d)
      pulses++;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One request, then a bounded wait for the done pulse.
  task automatic op(input logic prog, input logic [7:0] wa,
                    input logic [1:0] wb);
    int k;
    @(negedge core_clk_i);
    addr_i = wa;
    bit_i = wb;
    start_prog_i = prog;
    start_read_i = !prog;
    pulses = 0;
    @(negedge core_clk_i);
    start_prog_i = 1'b0;
    start_read_i = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20000)
    begin
      @(negedge core_clk_i);
      k++;
    end
    if (k >= 20000)
    begin
      fails++;
      end_sim();
    end
  endtask

  // Programs one bit and compares the pulse count and failure flag.
  task automatic prog_chk(input logic [7:0] wa, input logic [1:0] wb,
                          input int exp_p, input logic exp_f);
    op(1'b1, wa, wb);
    check("pulse count", pulses, exp_p);
    check("fail flag", fail, exp_f);
    if (!exp_f)
      exp_mem[wa] = exp_mem[wa] | (1 << wb);
    op(1'b0, wa, 2'h0);
    check("read word", rdata, exp_mem[wa]);
  endtask

  initial
  begin
    void'($urandom(32'h1ed5));
    foreach (exp_mem[i]) exp_mem[i] = 0;
    repeat (20) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    for (int i = 0; i < 4; i++)
    begin
      a = ADDR_W'($urandom);
      op(1'b0, a, 2'h0);
      check("blank word", rdata, exp_mem[a]);
    end
    $display("test blank read done");
    a = ADDR_W'($urandom);
    for (int b = 0; b < DATA_W; b++)
    begin
      n = 1 + int'($urandom % 5);
      need = 11'(n);
      prog_chk(a, 2'(b), n + 4, 1'b0);
    end
    $display("test program word done");
    need = 11'h7d0;
    prog_chk(a + 8'h01, 2'h2, 100, 1'b1);
    $display("test failing bit done");
    // Reset in the middle of a pulse train must drop every current at once.
    @(negedge core_clk_i);
    addr_i = a + 8'h02;
    bit_i = 2'h0;
    start_prog_i = 1'b1;
    @(negedge core_clk_i);
    start_prog_i = 1'b0;
    repeat (40) @(negedge core_clk_i);
    rst_b_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check("reset outputs", 32'({addr_o, ce1_b, ce2_b, prog_en, sense_en,
          busy, done, fail, rdata}), 32'h0001_8000);
    rst_b_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    $display("test mid-run reset done");
    // A fuse that reads one once and then zero at its re-check costs one
    // more main pulse before the four extra pulses.
    relapse = 1'b1;
    need = 11'h002;
    prog_chk(a + 8'h03, 2'h3, 7, 1'b0);
    relapse = 1'b0;
    $display("test relapsed bit done");
    prog_chk(a, 2'h1, 0, 1'b0);
    $display("test programmed bit done");
    end_sim();
  end
endmodule
`default_nettype wire
